// File: dv/apdc_far_model.sv
// far side model: monitor converter answering fine and coarse requests
`timescale 1ns/10ps
`default_nettype none
module apdc_far_model
  import apdc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic coarse_req,
  input wire logic fine_go,
  input wire logic [15:0] fine_val,
  input wire logic [15:0] coarse_val,
  output var apdc_mon_in_t mon_in
);
  logic [1:0] wait_ff; // cycles since a coarse request was seen
  // fine on command, coarse three cycles after a request
  always_ff @(posedge clk)
  begin
    mon_in.fine_valid <= 1'b0;
    mon_in.coarse_valid <= 1'b0;
    // value toggles between strobes so a stale sample never matches
    mon_in.value <= ~mon_in.value;
    if (srst)
    begin
      wait_ff <= 2'h0;
      mon_in.value <= 16'hA5A5;
    end
    else if (fine_go)
    begin
      mon_in.fine_valid <= 1'b1; // slice opens with fine
      mon_in.value <= fine_val;
      wait_ff <= 2'h0;
    end
    else if (coarse_req)
    begin
      wait_ff <= wait_ff + 2'h1;
      if (wait_ff == 2'h2)
      begin
        mon_in.coarse_valid <= 1'b1;
        mon_in.value <= coarse_val;
        wait_ff <= 2'h0;
      end
    end
  end
endmodule : apdc_far_model
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the bias converter and autorange block
`timescale 1ns/10ps
`default_nettype none
module tb
  import apdc_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
  logic reg_wr = 1'b0, reg_rd = 1'b0, coarse_req;
  apdc_mon_in_t mon_in;
  logic [15:0] rssi_result, fine_val = 16'h0, coarse_val = 16'h0;
  logic [7:0] feedback_input = 8'h00, photocurrent_level = 8'h00;
  logic [7:0] table_entry = 8'h00;
  logic table_valid = 1'b0, lut_valid = 1'b0, fine_go = 1'b0;
  logic [31:0] lut_word = 32'h0;
  logic level_two_password = 1'b0;
  logic switch_drive_output, second_digital_pin, photocurrent_quick_trip;
  logic [7:0] converter_setpoint_dac, first_aux_dac, monitor_indexed_dac;
  int failures = 0;
  int compares = 0;
  always #20 clk = ~clk;
  apdc_top dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .mon_in, .coarse_req, .rssi_result, .feedback_input,
    .photocurrent_level, .table_entry, .table_valid, .lut_word,
    .lut_valid, .level_two_password, .switch_drive_output,
    .second_digital_pin, .photocurrent_quick_trip, .converter_setpoint_dac,
    .first_aux_dac, .monitor_indexed_dac);
  apdc_far_model far (.clk, .srst, .coarse_req, .fine_go, .fine_val,
    .coarse_val, .mon_in);
  // one comparison, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // one monitor slice: fine, then coarse if the block asks
  task automatic slice(input logic [15:0] f, input logic [15:0] c,
    input logic req, input logic [15:0] res);
    int n;
    @(posedge clk);
    fine_val <= f;
    coarse_val <= c;
    fine_go <= 1'b1;
    @(posedge clk);
    fine_go <= 1'b0;
    @(posedge clk);
    #1;
    chk(coarse_req, req);
    n = 0;
    while (coarse_req === 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(coarse_req, 1'b0);
    chk(rssi_result, res);
    rd(8'h68, rv);
    chk(rv, res[15:8]);
    rd(8'h69, rv);
    chk(rv, res[7:0]);
  endtask : slice
  // measure one on time and period of the switch, bounded
  task automatic measure(output int hi, output int per);
    int n;
    n = 0;
    while (switch_drive_output !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    hi = 0;
    per = 0;
    while (switch_drive_output === 1'b1 && hi < 400)
    begin
      @(posedge clk);
      #1;
      hi++;
    end
    per = hi;
    while (switch_drive_output === 1'b0 && per < 400)
    begin
      @(posedge clk);
      #1;
      per++;
    end
  endtask : measure
  // reset values and zero duty while level sits at the bottom
  task automatic t_reset();
    int hi;
    rd(8'hFE, rv);
    chk(rv, 8'h00);
    rd(8'h80, rv);
    chk(rv & 8'h20, 8'h20);
    rd(8'h00, rv);
    chk(rv, 8'h00); // unmapped read
    hi = 0;
    repeat (200)
    begin
      @(posedge clk);
      #1;
      if (switch_drive_output !== 1'b0) hi++;
    end
    chk(hi, 0);
    $display("t_reset done");
  endtask : t_reset
  // both threshold edges for every shift count, with hysteresis
  task automatic t_range();
    logic [15:0] fmax [8] = '{16'hFFF8, 16'h7FFC, 16'h3FFE, 16'h1FFF,
      16'h0FFF, 16'h07FF, 16'h03FF, 16'h01FF};
    logic [15:0] cmin [8] = '{16'hF000, 16'h7800, 16'h3C00, 16'h1E00,
      16'h0F00, 16'h0780, 16'h03C0, 16'h01E0};
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h8E, 8'(s));
      slice(fmax[s], 16'h0, 1'b0, fmax[s]);
      slice(fmax[s] + 16'h1, cmin[s], 1'b1, cmin[s]);
      slice(16'h0010, cmin[s] - 16'h1, 1'b1, 16'h0010);
    end
    $display("t_range done");
  endtask : t_range
  task automatic t_force();
    wr(8'h89, 8'h01);
    slice(16'hFFFF, 16'h0, 1'b0, 16'hFFFF);
    wr(8'h89, 8'h02);
    slice(16'h0001, 16'h0005, 1'b1, 16'h0005);
    wr(8'h89, 8'h00);
    slice(16'h0002, 16'h0003, 1'b1, 16'h0002);
    slice(16'h0004, 16'h0, 1'b0, 16'h0004);
    $display("t_force done");
  endtask : t_force
  task automatic tbl(input logic [7:0] e);
    @(posedge clk);
    table_entry <= e;
    table_valid <= 1'b1;
    @(posedge clk);
    table_valid <= 1'b0;
    #1;
  endtask : tbl
  task automatic t_setpoint();
    tbl(8'h5A);
    chk(converter_setpoint_dac, 8'h5A);
    rd(8'hFE, rv);
    chk(rv, 8'h5A);
    wr(8'h80, 8'h00);
    tbl(8'h33);
    chk(converter_setpoint_dac, 8'h5A);
    wr(8'hFE, 8'h77);
    @(posedge clk);
    #1;
    chk(converter_setpoint_dac, 8'h77);
    $display("t_setpoint done");
  endtask : t_setpoint
  task automatic lut(input logic [7:0] sel);
    wr(8'hC7, sel);
    @(posedge clk);
    lut_valid <= 1'b1;
    @(posedge clk);
    lut_valid <= 1'b0;
    #1;
  endtask : lut
  // password gating and byte recall from the indexed table
  task automatic t_aux();
    wr(8'hC4, 8'h3C);
    @(posedge clk);
    #1;
    chk(first_aux_dac, 8'h00);
    @(posedge clk);
    level_two_password <= 1'b1;
    lut_word <= 32'h44332211;
    wr(8'hC4, 8'h3C);
    @(posedge clk);
    #1;
    chk(first_aux_dac, 8'h3C);
    for (int i = 0; i < 4; i++)
    begin
      lut(8'(i));
      chk(monitor_indexed_dac, 8'h11 * 8'(i + 1));
    end
    @(posedge clk);
    level_two_password <= 1'b0;
    lut(8'h00);
    chk(monitor_indexed_dac, 8'h44);
    $display("t_aux done");
  endtask : t_aux
  // ramp the level up, then period and capped on time per code
  task automatic t_pwm();
    int per_c [4] = '{190, 95, 47, 23};
    int hi_c [4] = '{171, 85, 42, 20};
    int hi, per;
    wr(8'h88, 8'h30);
    wr(8'hFE, 8'hFF);
    repeat (7000) @(posedge clk);
    for (int c = 3; c >= 0; c--)
    begin
      wr(8'h88, 8'(c << 4));
      measure(hi, per);
      measure(hi, per);
      chk(per, per_c[c]);
      chk(hi, hi_c[c]);
    end
    $display("t_pwm done");
  endtask : t_pwm
  task automatic trip(input logic [7:0] lvl);
    @(posedge clk);
    photocurrent_level <= lvl;
    @(posedge clk);
    #1;
  endtask : trip
  task automatic t_trip();
    int hi, per;
    wr(8'h88, 8'h30);
    wr(8'hC3, 8'h40);
    wr(8'h89, 8'h04);
    trip(8'h41);
    chk(photocurrent_quick_trip, 1'b1);
    chk(switch_drive_output, 1'b0);
    chk(second_digital_pin, 1'b1);
    measure(hi, per);
    chk(hi, 0);
    trip(8'h40);
    measure(hi, per);
    measure(hi, per);
    chk(photocurrent_quick_trip, 1'b0);
    chk(hi, 20);
    wr(8'h89, 8'h00);
    trip(8'h41);
    chk(photocurrent_quick_trip, 1'b1);
    chk(second_digital_pin, 1'b0);
    $display("t_trip done");
  endtask : t_trip
  task automatic wrap_up();
    $display("checks %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // main sequence after eight cycles of reset
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_range();
    t_force();
    t_setpoint();
    t_aux();
    t_pwm();
    t_trip();
    wrap_up();
  end
  // watchdog well past the expected run of some 10000 cycles
  initial
  begin
    #3000000;
    failures++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// File: rtl/apdc_consts.svh
// constants for the bias converter and monitor autorange block
`ifndef APDC_CONSTS_SVH
`define APDC_CONSTS_SVH
`define APDC_A_RESULT_HI 8'h68
`define APDC_A_RESULT_LO 8'h69
`define APDC_A_CTRL 8'h80
`define APDC_A_FREQ 8'h88
`define APDC_A_RANGE_CFG 8'h89
`define APDC_A_SHIFT 8'h8E
`define APDC_A_QT_THR 8'hC3
`define APDC_A_AUX1 8'hC4
`define APDC_A_LUT_SEL 8'hC7
`define APDC_A_SETPOINT 8'hFE
`define APDC_B_TBL_EN 5
`define APDC_B_FORCE_FINE 0
`define APDC_B_FORCE_COARSE 1
`define APDC_B_QT_PIN_EN 2
`define APDC_B_HALF_SEL 0
`define APDC_B_WIDTH_SEL 1
`define APDC_F_FREQ_LO 4
`define APDC_F_FREQ_HI 5
`define APDC_TH_FINE0 16'hFFF8
`define APDC_TH_FINE1 16'h7FFC
`define APDC_TH_FINE2 16'h3FFE
`define APDC_TH_FINE3 16'h1FFF
`define APDC_TH_FINE4 16'h0FFF
`define APDC_TH_FINE5 16'h07FF
`define APDC_TH_FINE6 16'h03FF
`define APDC_TH_FINE7 16'h01FF
`define APDC_TH_COARSE0 16'hF000
`define APDC_TH_COARSE1 16'h7800
`define APDC_TH_COARSE2 16'h3C00
`define APDC_TH_COARSE3 16'h1E00
`define APDC_TH_COARSE4 16'h0F00
`define APDC_TH_COARSE5 16'h0780
`define APDC_TH_COARSE6 16'h03C0
`define APDC_TH_COARSE7 16'h01E0
// clock and switching rates in units of 10 Hz
`define APDC_CLK_10HZ 2500000
`define APDC_FSW0_10HZ 13125
`define APDC_FSW1_10HZ 26250
`define APDC_FSW2_10HZ 52500
`define APDC_FSW3_10HZ 105000
`define APDC_DUTY_MAX_NUM 9
`define APDC_DUTY_MAX_DEN 10
`define APDC_RST_TBL_EN 1'b1
`endif

// File: rtl/apdc_pkg.sv
// types shared by the bias converter and monitor autorange block
package apdc_pkg;
  typedef enum logic [1:0] {
    APDC_IDLE = 2'b01,
    APDC_WAIT_COARSE = 2'b10
  } apdc_mon_st_t;

  // one monitor conversion strobe with its value
  typedef struct packed {
    logic fine_valid;
    logic coarse_valid;
    logic [15:0] value;
  } apdc_mon_in_t;

  typedef struct packed {
    apdc_mon_st_t mst;
    logic last_coarse;
    logic [15:0] fine_hold;
    logic [15:0] result;
    logic coarse_req;
    logic force_fine_range;
    logic force_coarse_range;
    logic qt_pin_en;
    logic tbl_en;
    logic [2:0] shift;
    logic [1:0] switch_freq_select;
    logic [7:0] qt_thr;
    logic [7:0] setpoint;
    logic [7:0] aux1;
    logic [7:0] idx_dac;
    logic table_width_select;
    logic byte_half_select;
    logic [7:0] cnt;
    logic [7:0] on_cyc;
    logic [7:0] comp;
    logic trip;
    logic drive;
    logic trip_pin;
    logic [7:0] rdata;
  } apdc_state_t;
endpackage : apdc_pkg

// File: rtl/apdc_top.sv
// bias converter pulse control, quick trip, aux dacs, monitor autorange
`timescale 1ns/10ps
`default_nettype none
`include "apdc_consts.svh"
module apdc_top
  import apdc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire apdc_mon_in_t mon_in,
  output logic coarse_req,
  output logic [15:0] rssi_result,
  input wire logic [7:0] feedback_input,
  input wire logic [7:0] photocurrent_level,
  input wire logic [7:0] table_entry,
  input wire logic table_valid,
  input wire logic [31:0] lut_word,
  input wire logic lut_valid,
  input wire logic level_two_password,
  output logic switch_drive_output,
  output logic second_digital_pin,
  output logic photocurrent_quick_trip,
  output logic [7:0] converter_setpoint_dac,
  output logic [7:0] first_aux_dac,
  output logic [7:0] monitor_indexed_dac
);

  apdc_state_t st_ff; // all state
  apdc_state_t nxt_st; // next state
  logic wr_hit_sp; // software write to setpoint
  logic [7:0] per; // current period in cycles
  logic fine_over; // fine result above upper threshold

  // upper fine threshold per shift count
  function automatic logic [15:0] fine_max(input logic [2:0] s);
    unique case (s)
      3'h0: fine_max = `APDC_TH_FINE0;
      3'h1: fine_max = `APDC_TH_FINE1;
      3'h2: fine_max = `APDC_TH_FINE2;
      3'h3: fine_max = `APDC_TH_FINE3;
      3'h4: fine_max = `APDC_TH_FINE4;
      3'h5: fine_max = `APDC_TH_FINE5;
      3'h6: fine_max = `APDC_TH_FINE6;
      3'h7: fine_max = `APDC_TH_FINE7;
    endcase
  endfunction : fine_max

  // lower coarse threshold per shift count
  function automatic logic [15:0] coarse_min(input logic [2:0] s);
    unique case (s)
      3'h0: coarse_min = `APDC_TH_COARSE0;
      3'h1: coarse_min = `APDC_TH_COARSE1;
      3'h2: coarse_min = `APDC_TH_COARSE2;
      3'h3: coarse_min = `APDC_TH_COARSE3;
      3'h4: coarse_min = `APDC_TH_COARSE4;
      3'h5: coarse_min = `APDC_TH_COARSE5;
      3'h6: coarse_min = `APDC_TH_COARSE6;
      3'h7: coarse_min = `APDC_TH_COARSE7;
    endcase
  endfunction : coarse_min

  // switching period in clock cycles, rounded down
  function automatic logic [7:0] period(input logic [1:0] f);
    unique case (f)
      2'h0: period = 8'(`APDC_CLK_10HZ / `APDC_FSW0_10HZ);
      2'h1: period = 8'(`APDC_CLK_10HZ / `APDC_FSW1_10HZ);
      2'h2: period = 8'(`APDC_CLK_10HZ / `APDC_FSW2_10HZ);
      2'h3: period = 8'(`APDC_CLK_10HZ / `APDC_FSW3_10HZ);
    endcase
  endfunction : period

  // on cycles of a period, capped at the maximum duty
  function automatic logic [7:0] duty_on(input logic [7:0] c,
                                         input logic [7:0] p);
    logic [15:0] prod;
    logic [15:0] cap;
    prod = ({8'h00, c} + 16'h0001) * p; // top level is a full period
    cap = 16'((p * `APDC_DUTY_MAX_NUM) / `APDC_DUTY_MAX_DEN);
    if (prod[15:8] > cap[7:0])
    begin
      duty_on = cap[7:0];
    end
    else
    begin
      duty_on = prod[15:8];
    end
  endfunction : duty_on

  assign per = period(st_ff.switch_freq_select);
  assign fine_over = mon_in.value > fine_max(st_ff.shift);
  assign wr_hit_sp = reg_wr && (reg_addr == `APDC_A_SETPOINT);

  // next state of every part of the block
  always_comb
  begin
    nxt_st = st_ff;
    // register writes; nonvolatile settings need the password
    if (reg_wr)
    begin
      unique case (reg_addr)
        `APDC_A_CTRL: nxt_st.tbl_en = reg_wdata[`APDC_B_TBL_EN];
        `APDC_A_FREQ: nxt_st.switch_freq_select =
          reg_wdata[`APDC_F_FREQ_HI:`APDC_F_FREQ_LO];
        `APDC_A_RANGE_CFG:
        begin
          nxt_st.force_fine_range = reg_wdata[`APDC_B_FORCE_FINE];
          nxt_st.force_coarse_range = reg_wdata[`APDC_B_FORCE_COARSE];
          nxt_st.qt_pin_en = reg_wdata[`APDC_B_QT_PIN_EN];
        end
        `APDC_A_SHIFT: nxt_st.shift = reg_wdata[2:0];
        `APDC_A_QT_THR: nxt_st.qt_thr = reg_wdata;
        `APDC_A_SETPOINT: nxt_st.setpoint = reg_wdata;
        `APDC_A_AUX1:
        begin
          if (level_two_password)
          begin
            nxt_st.aux1 = reg_wdata;
          end
        end
        `APDC_A_LUT_SEL:
        begin
          if (level_two_password)
          begin
            nxt_st.table_width_select = reg_wdata[`APDC_B_WIDTH_SEL];
            nxt_st.byte_half_select = reg_wdata[`APDC_B_HALF_SEL];
          end
        end
        default: ; // other addresses hold nothing here
      endcase
    end
    // table update; a software write in the same cycle wins
    if (st_ff.tbl_en && table_valid && !wr_hit_sp)
    begin
      nxt_st.setpoint = table_entry;
    end
    // indexed dac: pick one byte of the recalled word
    if (lut_valid)
    begin
      nxt_st.idx_dac = lut_word[{st_ff.table_width_select,
                               st_ff.byte_half_select, 3'h0} +: 8];
    end
    // register read, answered on the next edge
    nxt_st.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `APDC_A_RESULT_HI: nxt_st.rdata = st_ff.result[15:8];
        `APDC_A_RESULT_LO: nxt_st.rdata = st_ff.result[7:0];
        `APDC_A_CTRL: nxt_st.rdata[`APDC_B_TBL_EN] = st_ff.tbl_en;
        `APDC_A_FREQ: nxt_st.rdata[`APDC_F_FREQ_HI:`APDC_F_FREQ_LO] =
          st_ff.switch_freq_select;
        `APDC_A_RANGE_CFG:
        begin
          nxt_st.rdata[`APDC_B_FORCE_FINE] = st_ff.force_fine_range;
          nxt_st.rdata[`APDC_B_FORCE_COARSE] = st_ff.force_coarse_range;
          nxt_st.rdata[`APDC_B_QT_PIN_EN] = st_ff.qt_pin_en;
        end
        `APDC_A_SHIFT: nxt_st.rdata[2:0] = st_ff.shift;
        `APDC_A_QT_THR: nxt_st.rdata = st_ff.qt_thr;
        `APDC_A_SETPOINT: nxt_st.rdata = st_ff.setpoint;
        `APDC_A_AUX1: nxt_st.rdata = st_ff.aux1;
        `APDC_A_LUT_SEL:
        begin
          nxt_st.rdata[`APDC_B_WIDTH_SEL] = st_ff.table_width_select;
          nxt_st.rdata[`APDC_B_HALF_SEL] = st_ff.byte_half_select;
        end
        default: nxt_st.rdata = 8'h00; // unmapped reads zero
      endcase
    end
    // monitor slice: a fine result always opens it
    if (mon_in.fine_valid)
    begin
      nxt_st.fine_hold = mon_in.value;
      nxt_st.mst = APDC_IDLE;
      nxt_st.coarse_req = 1'b0;
      if (st_ff.force_coarse_range)
      begin
        nxt_st.coarse_req = 1'b1;
        nxt_st.mst = APDC_WAIT_COARSE;
      end
      else if (st_ff.force_fine_range)
      begin
        nxt_st.result = mon_in.value;
        nxt_st.last_coarse = 1'b0;
      end
      else if (fine_over || st_ff.last_coarse)
      begin
        // last slice coarse: stay coarse until it drops below minimum
        nxt_st.coarse_req = 1'b1;
        nxt_st.mst = APDC_WAIT_COARSE;
      end
      else
      begin
        nxt_st.result = mon_in.value;
      end
    end
    else if (st_ff.mst == APDC_WAIT_COARSE && mon_in.coarse_valid)
    begin
      nxt_st.coarse_req = 1'b0;
      nxt_st.mst = APDC_IDLE;
      if (!st_ff.force_coarse_range &&
          mon_in.value < coarse_min(st_ff.shift))
      begin
        // hysteresis band left: report the fine result instead
        nxt_st.result = st_ff.fine_hold;
        nxt_st.last_coarse = 1'b0;
      end
      else
      begin
        nxt_st.result = mon_in.value;
        nxt_st.last_coarse = 1'b1;
      end
    end
    // period counter; loads a new duty at each period start
    if (st_ff.cnt >= per - 8'h01)
    begin
      nxt_st.cnt = 8'h00;
      // integrate the error once per period, clamped both ends
      if (feedback_input < st_ff.setpoint &&
          st_ff.comp != 8'hFF)
      begin
        nxt_st.comp = st_ff.comp + 8'h01;
      end
      else if (feedback_input > st_ff.setpoint &&
               st_ff.comp != 8'h00)
      begin
        nxt_st.comp = st_ff.comp - 8'h01;
      end
      nxt_st.on_cyc = duty_on(nxt_st.comp, per);
      // fault released only at a period boundary
      if (photocurrent_level <= st_ff.qt_thr)
      begin
        nxt_st.trip = 1'b0;
      end
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
    end
    // a level above threshold always sets the fault, beating release
    if (photocurrent_level > st_ff.qt_thr)
    begin
      nxt_st.trip = 1'b1;
    end
    // a shorter new period could sit under an old, longer duty: drop it
    // until the next period start reloads it against the new length
    if (reg_wr && reg_addr == `APDC_A_FREQ)
    begin
      nxt_st.on_cyc = 8'h00;
    end
    nxt_st.drive = (nxt_st.cnt < nxt_st.on_cyc) && !nxt_st.trip;
    nxt_st.trip_pin = nxt_st.trip && nxt_st.qt_pin_en;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_ff <= '0;
      st_ff.mst <= APDC_IDLE;
      st_ff.tbl_en <= `APDC_RST_TBL_EN;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs all taken from the state register
  assign reg_rdata = st_ff.rdata;
  assign coarse_req = st_ff.coarse_req;
  assign rssi_result = st_ff.result;
  assign switch_drive_output = st_ff.drive;
  assign second_digital_pin = st_ff.trip_pin;
  assign photocurrent_quick_trip = st_ff.trip;
  assign converter_setpoint_dac = st_ff.setpoint;
  assign first_aux_dac = st_ff.aux1;
  assign monitor_indexed_dac = st_ff.idx_dac;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence auto_fine_over;
    mon_in.fine_valid && fine_over && !st_ff.force_fine_range;
  endsequence

  sequence coarse_arrives;
    st_ff.mst == APDC_WAIT_COARSE && mon_in.coarse_valid
      && !mon_in.fine_valid;
  endsequence

  fine_over_coarse_a: assert property (
    auto_fine_over |=> coarse_req && st_ff.mst == APDC_WAIT_COARSE)
    else $error("fine over threshold did not request coarse");
  coarse_min_ret_a: assert property (
    coarse_arrives ##0 (!st_ff.force_coarse_range &&
      mon_in.value < coarse_min(st_ff.shift))
    |=> rssi_result == $past(st_ff.fine_hold) && !st_ff.last_coarse)
    else $error("coarse below minimum not returned to fine");
  coarse_result_a: assert property (
    coarse_arrives ##0 (mon_in.value >= coarse_min(st_ff.shift))
    |=> rssi_result == $past(mon_in.value) && !coarse_req)
    else $error("coarse result not stored");
  forced_fine_a: assert property (
    mon_in.fine_valid && st_ff.force_fine_range
    && !st_ff.force_coarse_range
    |=> !coarse_req && rssi_result == $past(mon_in.value))
    else $error("forced fine requested coarse");
  table_write_a: assert property (
    st_ff.tbl_en && table_valid && !wr_hit_sp
    |=> converter_setpoint_dac == $past(table_entry))
    else $error("table entry not written to setpoint");
  manual_hold_a: assert property (
    !st_ff.tbl_en && !wr_hit_sp |=> $stable(converter_setpoint_dac))
    else $error("setpoint changed in manual mode");
  duty_cap_a: assert property (
    st_ff.on_cyc <= 8'(({8'h00, per} * 16'(`APDC_DUTY_MAX_NUM))
                       / 16'(`APDC_DUTY_MAX_DEN)))
    else $error("duty above maximum");
  trip_block_a: assert property (
    photocurrent_level > st_ff.qt_thr |=> photocurrent_quick_trip
      && !switch_drive_output)
    else $error("quick trip did not block pulses");
  trip_pin_a: assert property (
    photocurrent_quick_trip && st_ff.qt_pin_en |-> second_digital_pin)
    else $error("quick trip not on digital pin");
  trip_hold_a: assert property (
    photocurrent_quick_trip && st_ff.cnt < per - 8'h01
    |=> photocurrent_quick_trip)
    else $error("quick trip released inside a period");

endmodule : apdc_top
`default_nettype wire
